// [verilog/tmr_waveform.sv]
`include "tmr_consts.svh"

// Function
// - Reset clears compare output register.
// - Nonzero action overrides port value on pin.
// - Direction bit still controls pin drive.
// - Compare output settable before pin enabled.
// - Action zero leaves compare output unchanged.
// - New action acts next match; force immediate.
// - Mode alone sets counting; action sets output.
// - Normal mode counts up, wraps FF to 00.
// - Normal overflow set as counter becomes zero.
// - Counter writable anytime in normal mode.
// - Clear-on-match mode clears counter at match.
// - Unbuffered compare; low write runs to wrap.
// - Clear-on-match action one toggles on match.
// - Clear-on-match overflow set on MAX wrap.
// - Toggle period two times one plus compare.
// - Fast PWM counts zero to FF, restarts.
// - Fast PWM: action 2 non-inverting, 3 inverting.
// - Fast PWM overflow set on reaching MAX.
// - Fast PWM period is 256 timer clocks.
// - Compare zero spikes; compare MAX constant.
// - Fast PWM action one toggles, still buffered.
// - Match flag set one timer cycle later.
// - Counter write beats clear and count.
// - Compare buffered in PWM, direct otherwise.
// - Force reads zero, no flag, no clear.
module tmr_waveform (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Timer clock enable from the prescaler
  input  wire logic              timer_tick,
  // Configuration
  input  wire tmr_pkg::tmr_cfg_s  cfg,
  input  wire tmr_pkg::tmr_port_s port_bits,
  // Software accesses
  input  wire logic              cnt_wr,
  input  wire logic [7:0]        cnt_wdata,
  input  wire logic              cmp_wr,
  input  wire logic [7:0]        cmp_wdata,
  input  wire logic              force_compare_strobe,
  input  wire logic              overflow_clr,
  input  wire logic              match_clr,
  // Status
  output logic [7:0]             counter_value,
  output logic [7:0]             compare_value,
  output logic                   overflow_flag,
  output logic                   compare_match_flag,
  output logic                   compare_output,
  output logic                   force_readback,
  // Pin
  output logic                   pin_out,
  output logic                   pin_oe
);

  tmr_pkg::tmr_byte_t cnt_r;
  tmr_pkg::tmr_byte_t cnt_nxt;
  tmr_pkg::tmr_byte_t ocr_act_r;
  tmr_pkg::tmr_byte_t ocr_act_nxt;
  tmr_pkg::tmr_byte_t ocr_buf_r;
  tmr_pkg::tmr_byte_t ocr_buf_nxt;
  logic               ovf_r;
  logic               ovf_nxt;
  logic               cmf_r;
  logic               cmf_nxt;
  logic               oc_r;
  logic               oc_nxt;
  logic               blk_r;
  logic               blk_nxt;

  logic               pwm_mode;
  logic               match_c;
  logic               at_max;
  logic               step;
  logic               oc_hit;
  tmr_pkg::tmr_mode_e mode;
  logic [1:0]         act;

  assign mode     = cfg.waveform_mode_select;
  assign act      = cfg.compare_output_action;
  assign pwm_mode = (mode == tmr_pkg::TMR_FAST_PWM) ||
                    (mode == tmr_pkg::TMR_PHASE_PWM);
  assign at_max   = (cnt_r == `TMR_MAX);
  // A counter write blocks the match in the following timer cycle, so
  // software can preload the counter with the compare value safely.
  assign match_c  = (cnt_r == ocr_act_r) && !blk_r;
  // A write in the same cycle suppresses counting and clearing.
  assign step     = timer_tick && !cnt_wr;
  // Force only acts in the non-PWM modes.
  assign oc_hit   = (step && match_c) ||
                    (force_compare_strobe && !pwm_mode);

  always_comb begin
    cnt_nxt     = cnt_r;
    ocr_act_nxt = ocr_act_r;
    ocr_buf_nxt = ocr_buf_r;
    ovf_nxt     = ovf_r;
    cmf_nxt     = cmf_r;
    oc_nxt      = oc_r;
    blk_nxt     = blk_r;

    // Counting sequence follows the mode bits only.
    if (cnt_wr) begin
      cnt_nxt = cnt_wdata;
    end else if (step) begin
      unique case (mode)
        tmr_pkg::TMR_CLEAR_ON_MATCH: begin
          // Past the top the counter runs on to MAX and wraps.
          cnt_nxt = match_c ? `TMR_BOTTOM : cnt_r + `TMR_ONE;
        end
        tmr_pkg::TMR_FAST_PWM: begin
          cnt_nxt = at_max ? `TMR_BOTTOM : cnt_r + `TMR_ONE;
        end
        default: begin
          // Phase correct is not built here; it counts like normal.
          cnt_nxt = cnt_r + `TMR_ONE;
        end
      endcase
    end

    if (cnt_wr) begin
      blk_nxt = 1'b1;
    end else if (timer_tick) begin
      blk_nxt = 1'b0;
    end

    // Compare register: direct in non-PWM modes, buffered in PWM.
    if (cmp_wr) begin
      ocr_buf_nxt = cmp_wdata;
      if (!pwm_mode) begin
        ocr_act_nxt = cmp_wdata;
      end
    end
    if (pwm_mode && step && at_max) begin
      ocr_act_nxt = ocr_buf_r;
    end

    // Overflow flag; a set in the clearing cycle wins.
    if (overflow_clr) begin
      ovf_nxt = 1'b0;
    end
    if (step) begin
      if (mode == tmr_pkg::TMR_FAST_PWM) begin
        if (cnt_r == `TMR_BEFORE_MAX) begin
          ovf_nxt = 1'b1;
        end
      end else if (at_max) begin
        ovf_nxt = 1'b1;
      end
    end

    // Match flag rises with the timer cycle after the match.
    // A forced compare never sets it.
    if (match_clr) begin
      cmf_nxt = 1'b0;
    end
    if (step && match_c) begin
      cmf_nxt = 1'b1;
    end

    // Waveform generator; the action is sampled when the event occurs.
    if (mode == tmr_pkg::TMR_FAST_PWM) begin
      if (oc_hit) begin
        unique case (act)
          `TMR_ACT_TOGGLE: oc_nxt = !oc_r;
          `TMR_ACT_CLEAR:  oc_nxt = 1'b0;
          `TMR_ACT_SET:    oc_nxt = 1'b1;
          `TMR_ACT_NONE:   oc_nxt = oc_r;
        endcase
      end
      // The bottom event comes last so a compare of MAX holds a level.
      if (step && at_max) begin
        if (act == `TMR_ACT_CLEAR) begin
          oc_nxt = 1'b1;
        end else if (act == `TMR_ACT_SET) begin
          oc_nxt = 1'b0;
        end
      end
    end else if (!pwm_mode && oc_hit) begin
      unique case (act)
        `TMR_ACT_TOGGLE: oc_nxt = !oc_r;
        `TMR_ACT_CLEAR:  oc_nxt = 1'b0;
        `TMR_ACT_SET:    oc_nxt = 1'b1;
        `TMR_ACT_NONE:   oc_nxt = oc_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_r     <= `TMR_RST_COUNT;
      ocr_act_r <= `TMR_RST_CMP;
      ocr_buf_r <= `TMR_RST_CMP;
      ovf_r     <= 1'b0;
      cmf_r     <= 1'b0;
      oc_r      <= 1'b0;
      blk_r     <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      ocr_act_r <= ocr_act_nxt;
      ocr_buf_r <= ocr_buf_nxt;
      ovf_r     <= ovf_nxt;
      cmf_r     <= cmf_nxt;
      oc_r      <= oc_nxt;
      blk_r     <= blk_nxt;
    end
  end

  assign counter_value      = cnt_r;
  assign compare_value      = ocr_act_r;
  assign overflow_flag      = ovf_r;
  assign compare_match_flag = cmf_r;
  assign compare_output     = oc_r;

  // The force strobe has no storage; it always reads back as zero.
  always_ff @(posedge sys_clk) begin
    force_readback <= 1'b0;
  end

  // The compare output register is loaded independently of the pin
  // driver, so it can be preset before direction turns to output.
  tmr_pin_ctl u_pin (
    .sys_clk               (sys_clk),
    .resetn                (resetn),
    .compare_output_action (act),
    .port_bits             (port_bits),
    .compare_output        (oc_r),
    .pin_out               (pin_out),
    .pin_oe                (pin_oe)
  );

  // Checks other than a_reset_oc_clear start one cycle after reset is released, so the values that
  // $past sees are never taken from inside reset.
  logic chk_live_r;

  always_ff @(posedge sys_clk) begin
    chk_live_r <= resetn;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn || !chk_live_r);

  a_reset_oc_clear: assert property (
    disable iff (1'b0) !resetn |=> !oc_r)
    else $error("compare output not cleared by reset");

  a_pin_override: assert property (
    act != `TMR_ACT_NONE |=> pin_out == $past(oc_r))
    else $error("pin does not follow compare output");

  a_pin_direction: assert property (
    1'b1 |=> pin_oe == $past(port_bits.compare_pin_direction_bit))
    else $error("pin enable does not follow direction bit");

  a_no_action: assert property (
    act == `TMR_ACT_NONE |=> oc_r == $past(oc_r))
    else $error("compare output changed with no action");

  a_force_toggle: assert property (
    force_compare_strobe && !pwm_mode && act == `TMR_ACT_TOGGLE
    |=> oc_r != $past(oc_r))
    else $error("forced toggle did not act");

  a_normal_wrap: assert property (
    step && mode == tmr_pkg::TMR_NORMAL && at_max
    |=> cnt_r == `TMR_BOTTOM && ovf_r)
    else $error("normal wrap or overflow wrong");

  a_ctc_clear: assert property (
    step && mode == tmr_pkg::TMR_CLEAR_ON_MATCH && match_c
    |=> cnt_r == `TMR_BOTTOM && cmf_r)
    else $error("clear on match did not clear counter");

  a_ctc_toggle: assert property (
    step && mode == tmr_pkg::TMR_CLEAR_ON_MATCH && match_c &&
    act == `TMR_ACT_TOGGLE |=> oc_r != $past(oc_r))
    else $error("toggle on match missing");

  a_fast_flag: assert property (
    step && mode == tmr_pkg::TMR_FAST_PWM && cnt_r == `TMR_BEFORE_MAX
    |=> ovf_r && cnt_r == `TMR_MAX)
    else $error("fast PWM overflow not set at MAX");

  a_fast_bottom: assert property (
    step && mode == tmr_pkg::TMR_FAST_PWM && at_max &&
    act == `TMR_ACT_CLEAR |=> oc_r ##0 cnt_r == `TMR_BOTTOM)
    else $error("fast PWM bottom set missing");

  a_write_prio: assert property (
    cnt_wr |=> cnt_r == $past(cnt_wdata) ##1 (!cmf_r || $past(cmf_r)))
    else $error("counter write lost or match not blocked");

  a_force_no_flag: assert property (
    force_compare_strobe && !step && !cmf_r |=> !cmf_r)
    else $error("forced compare raised match flag");

  a_hold_idle: assert property (
    !timer_tick && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("counter moved without timer tick");

  c_ctc_toggle: cover property (
    step && mode == tmr_pkg::TMR_CLEAR_ON_MATCH && match_c &&
    act == `TMR_ACT_TOGGLE);
  c_fast_wrap: cover property (
    step && mode == tmr_pkg::TMR_FAST_PWM && at_max);
  c_write_block: cover property (cnt_wr ##1 timer_tick && blk_r);

endmodule // tmr_waveform

// [verilog/tmr_consts.svh]
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Counter extremes.
`define TMR_MAX        8'hFF
`define TMR_BEFORE_MAX 8'hFE
`define TMR_BOTTOM     8'h00
`define TMR_ONE        8'h01

// Compare output action codes.
`define TMR_ACT_NONE   2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR  2'h2
`define TMR_ACT_SET    2'h3

// Reset values.
`define TMR_RST_COUNT  8'h00
`define TMR_RST_CMP    8'h00

`endif

// [verilog/tmr_pkg.sv]
package tmr_pkg;

  // Waveform mode, in the order of the two select bits.
  typedef enum logic [1:0] {
    TMR_NORMAL,
    TMR_PHASE_PWM,
    TMR_CLEAR_ON_MATCH,
    TMR_FAST_PWM
  } tmr_mode_e;

  typedef logic [7:0] tmr_byte_t;

  // Configuration bits written by software.
  typedef struct packed {
    tmr_mode_e   waveform_mode_select;
    logic [1:0]  compare_output_action;
  } tmr_cfg_s;

  // Port pin bits; the compare unit may override the output register bit, never the direction bit.
  typedef struct packed {
    logic compare_pin_direction_bit;
    logic port_output_register;
  } tmr_port_s;

endpackage

// [verilog/tmr_pin_ctl.sv]
`include "tmr_consts.svh"

module tmr_pin_ctl (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Control
  input  wire logic [1:0]        compare_output_action,
  input  wire tmr_pkg::tmr_port_s port_bits,
  input  wire logic              compare_output,
  // Pin
  output logic                   pin_out,
  output logic                   pin_oe
);

  logic pin_out_nxt;
  logic pin_oe_nxt;

  always_comb begin
    // The override does not depend on the waveform mode.
    if (compare_output_action != `TMR_ACT_NONE) begin
      pin_out_nxt = compare_output;
    end else begin
      pin_out_nxt = port_bits.port_output_register;
    end
    // Direction stays with the port bit even while overridden.
    pin_oe_nxt = port_bits.compare_pin_direction_bit;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe  <= pin_oe_nxt;
    end
  end

endmodule // tmr_pin_ctl

// [tb/tmr_load.sv]
module tmr_load (
  // Clock
  input  wire logic        sys_clk,
  // Pin
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  // Measurements
  output logic      [15:0] period,
  output logic      [15:0] high_len,
  output logic      [15:0] edges
);
  timeunit 1ns;
  timeprecision 100ps;
  // The load pulls the line low, so an undriven pin reads as zero.
  logic        lvl;
  logic        prev = 1'b0;
  logic [15:0] rc = 16'h0001;
  logic [15:0] hc = 16'h0000;
  initial begin
    period = 16'h0000;
    high_len = 16'h0000;
    edges = 16'h0000;
  end
  assign lvl = pin_oe ? pin_out : 1'b0;
  always @(posedge sys_clk) begin
    prev <= lvl;
    rc <= (lvl && !prev) ? 16'h0001 : rc + 16'h0001;
    hc <= lvl ? hc + 16'h0001 : 16'h0000;
    if (lvl && !prev) begin
      period <= rc;
      edges <= edges + 16'h0001;
    end
    if (!lvl && prev) begin
      high_len <= hc;
    end
  end
endmodule // tmr_load

// [tb/timer8_compare_waveform_tb.sv]
module timer8_compare_waveform_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               sys_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               tick = 1'b1;
  tmr_pkg::tmr_cfg_s  cfg = '0;
  tmr_pkg::tmr_port_s pb = '0;
  logic               cw = 1'b0, mw = 1'b0, frc = 1'b0;
  logic               oclr = 1'b0, mclr = 1'b0;
  logic [7:0]         cd = 8'h00, md = 8'h00, c0, cnt, cmp;
  logic               ovf, mf, oc, frb, po, poe, o0;
  logic [15:0]        per, hi, ed, e0;
  int                 fail_count = 0;
  int                 compares = 0;
  logic [1:0] ta [6] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h1};
  logic [7:0] tc [6] = '{8'h40, 8'h40, 8'h00, 8'hFF, 8'hFF, 8'h40};
  logic [9:0] th [6] = '{10'h041, 10'h0BF, 10'h001, 10'h001, 10'h000,
                         10'h100};
  logic [9:0] tp [6] = '{10'h100, 10'h100, 10'h100, 10'h000, 10'h000,
                         10'h200};

  tmr_waveform uut (
    .sys_clk(sys_clk), .resetn(resetn), .timer_tick(tick), .cfg(cfg),
    .port_bits(pb), .cnt_wr(cw), .cnt_wdata(cd), .cmp_wr(mw),
    .cmp_wdata(md), .force_compare_strobe(frc), .overflow_clr(oclr),
    .match_clr(mclr), .counter_value(cnt), .compare_value(cmp),
    .overflow_flag(ovf), .compare_match_flag(mf), .compare_output(oc),
    .force_readback(frb), .pin_out(po), .pin_oe(poe)
  );
  tmr_load load (
    .sys_clk(sys_clk), .pin_out(po), .pin_oe(poe), .period(per),
    .high_len(hi), .edges(ed)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic smp(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wcnt(input logic [7:0] v);
    @(posedge sys_clk);
    cw <= 1'b1;
    cd <= v;
    @(posedge sys_clk);
    cw <= 1'b0;
  endtask
  task automatic wcmp(input logic [7:0] v);
    @(posedge sys_clk);
    mw <= 1'b1;
    md <= v;
    @(posedge sys_clk);
    mw <= 1'b0;
  endtask
  // Strobes in the order force, overflow clear, match clear.
  task automatic pls(input logic [2:0] w);
    @(posedge sys_clk);
    {frc, oclr, mclr} <= w;
    @(posedge sys_clk);
    {frc, oclr, mclr} <= 3'h0;
  endtask
  task automatic wovf(input int lim);
    int i;
    i = 0;
    do begin
      smp(1);
      i++;
    end while (ovf !== 1'b1 && i < lim);
    if (ovf !== 1'b1) begin
      chk("ovf_wait", {15'h0000, ovf}, 16'h0001);
      conclude();
    end
  endtask

  initial begin
    cyc(2);
    resetn <= 1'b1;
    smp(1);
    chk("cnt", cnt, 16'h0000);
    chk("outs", {cmp, ovf, mf, oc, po, poe, frb}, 16'h0000);
    pls(3'h1);
    wcnt(8'hFE);
    smp(1);
    chk("cnt", cnt, 16'h00FE);
    smp(1);
    chk("ovf", {cnt, ovf}, {8'hFF, 1'b0});
    smp(1);
    chk("wrap", {cnt, ovf, mf}, {8'h00, 2'b10});
    smp(1);
    chk("match", {mf, oc}, 2'b10);
    @(posedge sys_clk) tick <= 1'b0;
    smp(1);
    c0 = cnt;
    smp(4);
    chk("hold", cnt, c0);
    @(posedge sys_clk) cfg <= '{tmr_pkg::TMR_NORMAL, 2'h3};
    pls(3'h4);
    smp(1);
    chk("force", {oc, poe, po, frb}, 4'h8);
    @(posedge sys_clk) pb <= 2'h2;
    smp(3);
    chk("pin", {po, poe}, 2'h3);
    // A reset in mid-run clears the compare output that drives the pin.
    @(posedge sys_clk) resetn <= 1'b0;
    @(posedge sys_clk) resetn <= 1'b1;
    smp(1);
    chk("mrst", {cnt, oc, po, poe, ovf, mf}, 16'h0000);
    pls(3'h4);
    @(posedge sys_clk) cfg.compare_output_action <= 2'h0;
    smp(3);
    chk("port", {po, oc}, 2'h1);
    @(posedge sys_clk) cfg.compare_output_action <= 2'h2;
    pls(3'h4);
    smp(1);
    chk("fclr", oc, 16'h0000);
    @(posedge sys_clk) cfg <= '{tmr_pkg::TMR_PHASE_PWM, 2'h3};
    pls(3'h4);
    smp(1);
    chk("pwmforce", oc, 16'h0000);
    @(posedge sys_clk) cfg <= '{tmr_pkg::TMR_CLEAR_ON_MATCH, 2'h1};
    smp(1);
    o0 = oc;
    c0 = cnt;
    pls(3'h1);
    pls(3'h4);
    smp(1);
    chk("ctcforce", {oc, mf, cnt}, {~o0, 1'b0, c0});
    wcmp(8'h03);
    wcnt(8'h00);
    @(posedge sys_clk) tick <= 1'b1;
    c0 = 8'h00;
    repeat (40) begin
      smp(1);
      if (cnt > c0) c0 = cnt;
    end
    chk("top", c0, 16'h0003);
    chk("per", per, 16'h0008);
    chk("hi", hi, 16'h0004);
    wcnt(8'h10);
    pls(3'h2);
    wovf(300);
    chk("late", cnt, 16'h0000);
    // Compare zero toggles on every timer clock after the wrap.
    wcmp(8'h00);
    cyc(300);
    chk("half", per, 16'h0002);
    chk("halfhi", hi, 16'h0001);
    wcmp(8'h03);
    // Compare stays in the buffer until the counter wraps.
    @(posedge sys_clk) cfg <= '{tmr_pkg::TMR_FAST_PWM, 2'h2};
    wcmp(8'h40);
    smp(1);
    chk("buf", cmp, 16'h0003);
    pls(3'h2);
    wovf(300);
    chk("fovf", cnt, 16'h00FF);
    smp(2);
    chk("load", cmp, 16'h0040);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk) cfg <= '{tmr_pkg::TMR_FAST_PWM, ta[i]};
      wcmp(tc[i]);
      cyc(tp[i] == 0 ? 300 : 2 * tp[i] + 200);
      e0 = ed;
      cyc(tp[i] == 0 ? 300 : 1);
      if (tp[i] == 0) begin
        chk("flat", {ed == e0, po}, {1'b1, th[i][0]});
      end else begin
        chk("fper", per, tp[i]);
        chk("fhi", hi, th[i]);
      end
    end
    conclude();
  end
endmodule // timer8_compare_waveform_tb
